// >>> design/pin_sync.sv
/*
 * Three-stage synchroniser for pins and foreign levels; a new value is
 * accepted only once the second and third stages agree.
 * Assumes synchronous active-low reset on clk_sys.
 */
`timescale 1ns/1ps

module pin_sync #(
    parameter int W = 7,
    parameter logic [W-1:0] INIT = '0
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // Lanes
    sync_if.syncer   lanes
);
    logic [W-1:0] s1_r;
    logic [W-1:0] s2_r;
    logic [W-1:0] s3_r;
    logic [W-1:0] out_r;
    logic [W-1:0] agree;

    assign agree = ~(s2_r ^ s3_r);
    assign lanes.synced = out_r;

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            s1_r  <= INIT;
            s2_r  <= INIT;
            s3_r  <= INIT;
            out_r <= INIT;
        end else begin
            s1_r  <= lanes.raw;
            s2_r  <= s1_r;
            s3_r  <= s2_r;
            out_r <= (s3_r & agree) | (out_r & ~agree);
        end
    end

    // A change only follows two agreeing late stages
    AST_SYNC_AGREE: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (out_r != $past(out_r)) |->
        (((out_r ^ $past(out_r)) & ($past(s2_r) ^ $past(s3_r))) == '0))
        else $error("synchroniser output changed without agreement");

endmodule : pin_sync

// >>> design/power_sleep_wake_reset_ctrl.sv
/*
 * Power-mode and reset sequencer of the always-on logic: power-on
 * sequencing, sleep entry and exit, wake-up, interrupt masking and the
 * active-low reset output.
 * Assumes one 100 MHz clock, synchronous active-low power-on reset, and
 * one-cycle write strobes from the serial interface on the same clock.
 */
// Notes on behaviour
// - After power-on the supervisor is on, user pins are inputs with pull-ups.
// - Clock outputs start only after supervisor release plus a timeout.
// - After power-on all interrupts are masked except the clock-locked flag.
// - Converter, pump, reference, op amps, DACs and switches start disabled.
// - Sleep powers down all blocks but interface, registers, bandgap, enabled helpers.
// - Each analog block has its own independent power-down control.
// - A write to the sleep address sets the shutdown flag and sleeps.
// - The sleep pin forces sleep over writes and wake, shutdown flag untouched.
// - Writing one to the sleep request bit sets the shutdown flag.
// - Sleep equals shutdown flag OR asserted sleep pin function.
// - With flag clear, releasing the sleep pin returns to normal mode.
// - With sleep pin released, a normal-mode write clears the flag.
// - With sleep pin released, wake pin or day alarm leaves sleep.
// - A wake event in normal mode is only recorded in status.
// - Reset output low on POR, gated supply trip, watchdog, crystal, clock not ready.
// - With reset enable clear, supply trips only raise interrupt and status flag.
// - Reset enable lets the supply detector drive reset; defaults to one.
`timescale 1ns/1ps
`include "psw_defines.svh"

module power_sleep_wake_reset_ctrl import psw_pkg::*; #(
    parameter int TIMEOUT_CYCLES = `POR_TIMEOUT_CYC,
    parameter int WDOG_CYCLES    = `WDOG_RST_CYC,
    parameter int USER_PINS      = `USER_PINS,
    parameter int ANALOG_BLOCKS  = `ANALOG_BLOCKS
) (
    // Clock and power-on reset
    input  wire logic                     clk_sys,
    input  wire logic                     rst_n,
    // Asynchronous levels
    input  wire logic                     sleep_pin,
    input  wire logic                     wake_pin,
    input  wire logic                     supply_low,
    input  wire logic                     supervisor_ok,
    input  wire logic                     clk32_ready,
    input  wire logic                     crystal_attached,
    input  wire logic                     fll_locked,
    // Pin function configuration
    input  wire logic                     sleep_func_en,
    input  wire logic                     sleep_active_low,
    input  wire logic                     wakeup_pin_function,
    input  wire logic                     wake_active_low,
    input  wire logic                     osc_keep_in_sleep,
    // Serial writes and events on clk_sys
    input  wire logic                     sleep_reg_wr,
    input  wire logic                     sleep_cfg_wr,
    input  wire logic                     sleep_request_bit,
    input  wire logic                     normal_reg_wr,
    input  wire logic                     day_alarm,
    input  wire logic                     watchdog_expired,
    input  wire logic                     status_rd,
    // Supply monitor control
    input  wire logic                     supply_monitor_ctrl_wr,
    input  wire logic                     supply_detect_wdata,
    input  wire logic                     reset_enable_wdata,
    // Interrupt mask
    input  wire logic                     irq_mask_wr,
    input  wire logic [`IRQ_SRC_COUNT-1:0] irq_mask_wdata,
    // Per-block analog power control
    input  wire logic                     analog_wr,
    input  wire logic [ANALOG_BLOCKS-1:0] analog_sel,
    input  wire logic [ANALOG_BLOCKS-1:0] analog_wdata,
    // User pin configuration
    input  wire logic                     pin_cfg_wr,
    input  wire logic [USER_PINS-1:0]     pin_drive_wdata,
    input  wire logic [USER_PINS-1:0]     pin_pull_wdata,
    // Mode and power outputs
    output logic                          sleep_mode,
    output logic                          shutdown_flag,
    output logic                          hf_clock_out_en,
    output logic                          low_freq_clock_out_en,
    output logic                          supervisor_en,
    output logic [ANALOG_BLOCKS-1:0]      analog_pwr_en,
    output logic [USER_PINS-1:0]          pin_oe_n,
    output logic [USER_PINS-1:0]          pin_pullup_en,
    // Status, interrupt and reset
    output logic                          clock_locked_flag,
    output logic                          low_digital_supply_flag,
    output logic                          wake_event_flag,
    output logic                          reset_output_enable,
    output logic                          irq_out,
    output logic                          reset_out_n
);
    localparam int TW = $clog2(TIMEOUT_CYCLES + 1);
    localparam int WW = $clog2(WDOG_CYCLES + 1);

    function automatic logic pin_active(input logic level, input logic active_low);
        pin_active = level ^ active_low;
    endfunction : pin_active

    sync_if #(.W(`SYN_WIDTH)) lanes ();

    assign lanes.raw = {fll_locked, crystal_attached, clk32_ready, supervisor_ok,
                        supply_low, wake_pin, sleep_pin};

    pin_sync #(.W(`SYN_WIDTH), .INIT(7'h00)) u_sync (
        .clk_sys (clk_sys),
        .rst_n   (rst_n),
        .lanes   (lanes)
    );

    power_state_t      state_r;
    power_state_t      state_nxt;
    logic [TW-1:0]     tmo_r;
    logic [WW-1:0]     wdog_r;
    logic              wake_d_r;
    logic              fll_d_r;
    logic              supply_detect_r;
    logic [`IRQ_SRC_COUNT-1:0] irq_mask_r;
    logic [ANALOG_BLOCKS-1:0]  analog_en_r;

    // Decoding of levels and events
    wire pin_sleep   = sleep_func_en & pin_active(lanes.synced[`SYN_SLEEP], sleep_active_low);
    wire wake_lvl    = wakeup_pin_function &
                       pin_active(lanes.synced[`SYN_WAKE], wake_active_low);
    wire wake_evt    = (wake_lvl & ~wake_d_r) | day_alarm;
    wire fll_rise    = lanes.synced[`SYN_FLL] & ~fll_d_r;
    wire low_sup     = lanes.synced[`SYN_LOWSUP] & supply_detect_r;
    wire sd_set      = sleep_reg_wr | (sleep_cfg_wr & sleep_request_bit);
    wire sd_clr      = ~pin_sleep & (normal_reg_wr | wake_evt);
    wire shutdown_nxt = sd_set | (shutdown_flag & ~sd_clr);
    wire sleep_nxt   = shutdown_nxt | pin_sleep;
    wire run         = (state_r == PS_RUN);
    wire [ANALOG_BLOCKS-1:0] analog_nxt = analog_wr ?
                       ((analog_en_r & ~analog_sel) | (analog_wdata & analog_sel)) : analog_en_r;
    wire rst_en_nxt  = supply_monitor_ctrl_wr ? reset_enable_wdata : reset_output_enable;
    wire rst_cause   = (low_sup & rst_en_nxt) | (wdog_r != '0) | watchdog_expired |
                       lanes.synced[`SYN_XTAL] | ~lanes.synced[`SYN_CLK32];
    wire wake_flag_nxt = wake_evt | (wake_event_flag & ~status_rd);
    wire lock_flag_nxt = fll_rise | (clock_locked_flag & ~status_rd);
    wire ldv_flag_nxt  = low_sup | (low_digital_supply_flag & ~status_rd);
    wire [`IRQ_SRC_COUNT-1:0] irq_mask_nxt = irq_mask_wr ? irq_mask_wdata : irq_mask_r;
    wire [`IRQ_SRC_COUNT-1:0] pend_nxt = {wake_flag_nxt, ldv_flag_nxt, lock_flag_nxt};

    // Clocks wait for the supervisor, then for the timeout
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            PS_HOLD: begin
                if (lanes.synced[`SYN_SUPOK]) begin
                    state_nxt = PS_TIMEOUT;
                end
            end
            PS_TIMEOUT: begin
                if (!lanes.synced[`SYN_SUPOK]) begin
                    state_nxt = PS_HOLD;
                end else if (tmo_r == TW'(TIMEOUT_CYCLES - 1)) begin
                    state_nxt = PS_RUN;
                end
            end
            PS_RUN: begin
                if (!lanes.synced[`SYN_SUPOK]) begin
                    state_nxt = PS_HOLD;
                end
            end
            default: begin
                state_nxt = PS_HOLD;
            end
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            state_r <= PS_HOLD;
            tmo_r   <= '0;
        end else begin
            state_r <= state_nxt;
            tmo_r   <= (state_r == PS_TIMEOUT) ? tmo_r + TW'(1) : '0;
        end
    end

    // Mode, enables and pin setup
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            shutdown_flag         <= 1'b0;
            sleep_mode            <= 1'b0;
            hf_clock_out_en       <= 1'b0;
            low_freq_clock_out_en <= 1'b0;
            analog_en_r           <= '0;
            analog_pwr_en         <= '0;
            supply_detect_r       <= 1'b1;
            supervisor_en         <= 1'b1;
            pin_oe_n              <= '1;
            pin_pullup_en         <= '1;
        end else begin
            shutdown_flag         <= shutdown_nxt;
            sleep_mode            <= sleep_nxt;
            hf_clock_out_en       <= run & ~sleep_nxt;
            low_freq_clock_out_en <= run & (~sleep_nxt | osc_keep_in_sleep);
            analog_en_r           <= analog_nxt;
            analog_pwr_en         <= analog_nxt & {ANALOG_BLOCKS{~sleep_nxt}};
            if (supply_monitor_ctrl_wr) begin
                supply_detect_r <= supply_detect_wdata;
                supervisor_en   <= supply_detect_wdata;
            end
            if (pin_cfg_wr) begin
                pin_oe_n      <= ~pin_drive_wdata;
                pin_pullup_en <= pin_pull_wdata;
            end
        end
    end

    // Status flags: an event in the read cycle survives the clear
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            wake_d_r                <= 1'b0;
            fll_d_r                 <= 1'b0;
            wake_event_flag         <= 1'b0;
            clock_locked_flag       <= 1'b0;
            low_digital_supply_flag <= 1'b0;
            irq_mask_r              <= `IRQ_MASK_POR;
            irq_out                 <= 1'b0;
        end else begin
            wake_d_r                <= wake_lvl;
            fll_d_r                 <= lanes.synced[`SYN_FLL];
            wake_event_flag         <= wake_flag_nxt;
            clock_locked_flag       <= lock_flag_nxt;
            low_digital_supply_flag <= ldv_flag_nxt;
            irq_mask_r              <= irq_mask_nxt;
            irq_out                 <= |(pend_nxt & ~irq_mask_nxt);
        end
    end

    // Reset output; a watchdog expiry is stretched so the host sees it
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            reset_output_enable <= 1'b1;
            wdog_r              <= '0;
            reset_out_n         <= 1'b0;
        end else begin
            reset_output_enable <= rst_en_nxt;
            if (watchdog_expired) begin
                wdog_r <= WW'(WDOG_CYCLES - 1);
            end else if (wdog_r != '0) begin
                wdog_r <= wdog_r - WW'(1);
            end
            reset_out_n <= ~rst_cause;
        end
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    AST_POR_PINS: assert property ($rose(rst_n) |->
        pin_oe_n == '1 && pin_pullup_en == '1 && supervisor_en)
        else $error("pins or supervisor wrong after power-on");
    AST_CLK_HOLD: assert property ((state_r != PS_RUN) |=> !hf_clock_out_en &&
        !low_freq_clock_out_en)
        else $error("clock output before timeout expired");
    AST_IRQ_POR: assert property ($rose(rst_n) |-> irq_mask_r == `IRQ_MASK_POR)
        else $error("interrupt mask wrong after power-on");
    AST_ANALOG_POR: assert property ($rose(rst_n) |-> analog_pwr_en == '0)
        else $error("analog block powered after power-on");
    AST_SLEEP_PWR: assert property (sleep_mode |-> analog_pwr_en == '0 &&
        !hf_clock_out_en)
        else $error("block powered in sleep");
    AST_SLEEP_WR: assert property ((sleep_reg_wr || (sleep_cfg_wr && sleep_request_bit))
        |=> shutdown_flag && sleep_mode)
        else $error("sleep write did not enter sleep");
    AST_PIN_SLEEP: assert property ((pin_sleep && !sd_set) |=>
        sleep_mode && shutdown_flag == $past(shutdown_flag))
        else $error("sleep pin did not force sleep or moved the flag");
    AST_PIN_EXIT: assert property ((pin_sleep && !shutdown_flag && !sd_set) ##1
        (!pin_sleep && !sd_set) |=> !sleep_mode)
        else $error("releasing sleep pin did not resume normal mode");
    AST_NORMAL_WR: assert property ((normal_reg_wr && !pin_sleep && !sd_set) |=>
        !shutdown_flag && !sleep_mode)
        else $error("normal write did not clear shutdown");
    AST_WAKE: assert property ((wake_evt && !pin_sleep && !sd_set) |=>
        !sleep_mode ##0 wake_event_flag)
        else $error("wake event did not leave sleep");
    AST_RST_OUT: assert property ((low_sup && rst_en_nxt) |=> !reset_out_n)
        else $error("supply trip did not pull reset low");
    AST_RST_GATE: assert property ((!rst_cause) |=> reset_out_n)
        else $error("reset low without a cause");
    AST_WDOG: assert property (watchdog_expired |=> !reset_out_n [*2])
        else $error("watchdog reset pulse too short");
    AST_WAKE_NORMAL: assert property ((wake_evt && !sleep_mode && !pin_sleep && !sd_set)
        |=> !sleep_mode && wake_event_flag)
        else $error("wake event in normal mode changed the mode");
    AST_LOCK_IRQ: assert property (fll_rise |=> clock_locked_flag &&
        (irq_out || irq_mask_r[0]))
        else $error("unmasked clock lock did not raise the interrupt");
    AST_RST_EN_POR: assert property ($rose(rst_n) |-> reset_output_enable && !reset_out_n)
        else $error("reset enable or reset output wrong after power-on");

    COV_PIN_SLEEP: cover property (pin_sleep ##1 sleep_mode ##[1:20] !sleep_mode);
    COV_SW_SLEEP_WAKE: cover property (sleep_reg_wr ##[1:50] (wake_evt && !pin_sleep));
    COV_RUN: cover property ($rose(hf_clock_out_en));
    COV_SUPPLY_IRQ: cover property (!reset_output_enable && low_sup ##1 irq_out);

endmodule : power_sleep_wake_reset_ctrl

// >>> design/psw_defines.svh
/*
 * Constants of the power, sleep, wake-up and reset sequencer: synchroniser
 * lane indices, power-on values and timing counts.
 * Assumes a 100 MHz system clock; included by bare name.
 */
`ifndef PSW_DEFINES_SVH
`define PSW_DEFINES_SVH

`define CLK_SYS_MHZ       100
// Delay after the supply supervisor releases before clocks leave the device
`define POR_TIMEOUT_US    2000
`define POR_TIMEOUT_CYC   (`POR_TIMEOUT_US * `CLK_SYS_MHZ)
// Least width of the reset pulse that a watchdog expiry produces
`define WDOG_RST_NS       1000
`define WDOG_RST_CYC      ((`WDOG_RST_NS * `CLK_SYS_MHZ + 999) / 1000)

// Lanes of the pin synchroniser
`define SYN_WIDTH         7
`define SYN_SLEEP         0
`define SYN_WAKE          1
`define SYN_LOWSUP        2
`define SYN_SUPOK         3
`define SYN_CLK32         4
`define SYN_XTAL          5
`define SYN_FLL           6

// Interrupt sources: 0 clock locked, 1 low supply, 2 wake-up; 1 = masked
`define IRQ_SRC_COUNT     3
`define IRQ_MASK_POR      3'h6

`define USER_PINS         4
`define ANALOG_BLOCKS     6

`endif

// >>> design/psw_pkg.sv
/*
 * Types of the power, sleep, wake-up and reset sequencer.
 * Assumes nothing beyond the constants header.
 */
package psw_pkg;

    typedef enum logic [1:0] {
        PS_HOLD,
        PS_TIMEOUT,
        PS_RUN
    } power_state_t;

endpackage : psw_pkg

// >>> design/sync_if.sv
/*
 * Carrier between the sequencer and its pin synchroniser.
 * Assumes both ends run on clk_sys.
 */
`timescale 1ns/1ps

interface sync_if #(parameter int W = 7);
    logic [W-1:0] raw;
    logic [W-1:0] synced;

    modport owner (output raw, input synced);
    modport syncer (input raw, output synced);
endinterface : sync_if

// >>> tb/host_pin_model.sv
/*
 * Host-side model of the two user pins that carry the sleep and wake-up
 * functions: the bench asks for a logical assertion, the model puts the
 * level on the pin in the polarity that the device is configured for.
 * Assumes the bench changes its requests only just after a falling edge.
 */
`timescale 1ns/1ps

module host_pin_model (
    // Logical requests from the bench
    input  wire logic sleep_req,
    input  wire logic wake_req,
    // Polarity the device expects
    input  wire logic sleep_active_low,
    input  wire logic wake_active_low,
    // Pins towards the device
    output logic      sleep_pin,
    output logic      wake_pin
);
    // Deasserted pins rest at the level opposite to the asserted one
    assign sleep_pin = sleep_req ^ sleep_active_low;
    assign wake_pin  = wake_req ^ wake_active_low;
endmodule : host_pin_model

// >>> tb/test_power_sleep_wake_reset_ctrl.sv
/*
 * Self-checking bench of the power, sleep, wake-up and reset sequencer.
 * Assumes the design's constants header and package; all inputs move
 * on the falling edge, outputs are read on the falling edge.
 */
`timescale 1ns/1ps
`include "psw_defines.svh"

module test_power_sleep_wake_reset_ctrl import psw_pkg::*; ;
    localparam int TO = 20;
    localparam int WD = 4;
    logic       clk_sys = 1'h0;
    logic       rst_n, sleep_pin, wake_pin, supply_low, supervisor_ok, clk32_ready;
    logic       crystal_attached, fll_locked, sleep_func_en, sleep_active_low;
    logic       wakeup_pin_function, wake_active_low, osc_keep_in_sleep, sleep_reg_wr;
    logic       sleep_cfg_wr, sleep_request_bit, normal_reg_wr, day_alarm, status_rd;
    logic       watchdog_expired, supply_monitor_ctrl_wr, supply_detect_wdata;
    logic       reset_enable_wdata, irq_mask_wr, analog_wr, pin_cfg_wr, sleep_req, wake_req;
    logic       sleep_mode, shutdown_flag, hf_clock_out_en, low_freq_clock_out_en;
    logic       supervisor_en, clock_locked_flag, low_digital_supply_flag, wake_event_flag;
    logic       reset_output_enable, irq_out, reset_out_n;
    logic [`IRQ_SRC_COUNT-1:0] irq_mask_wdata;
    logic [5:0] analog_sel, analog_wdata, analog_pwr_en;
    logic [3:0] pin_drive_wdata, pin_pull_wdata, pin_oe_n, pin_pullup_en;
    int         failures = 0;
    int         total_checks = 0;

    power_sleep_wake_reset_ctrl #(.TIMEOUT_CYCLES(TO), .WDOG_CYCLES(WD))
        power_sleep_wake_reset_ctrl_inst (
        .clk_sys, .rst_n, .sleep_pin, .wake_pin, .supply_low, .supervisor_ok, .clk32_ready,
        .crystal_attached, .fll_locked, .sleep_func_en, .sleep_active_low,
        .wakeup_pin_function, .wake_active_low, .osc_keep_in_sleep, .sleep_reg_wr,
        .sleep_cfg_wr, .sleep_request_bit, .normal_reg_wr, .day_alarm, .watchdog_expired,
        .status_rd, .supply_monitor_ctrl_wr, .supply_detect_wdata, .reset_enable_wdata,
        .irq_mask_wr, .irq_mask_wdata, .analog_wr, .analog_sel, .analog_wdata, .pin_cfg_wr,
        .pin_drive_wdata, .pin_pull_wdata, .sleep_mode, .shutdown_flag, .hf_clock_out_en,
        .low_freq_clock_out_en, .supervisor_en, .analog_pwr_en, .pin_oe_n, .pin_pullup_en,
        .clock_locked_flag, .low_digital_supply_flag, .wake_event_flag,
        .reset_output_enable, .irq_out, .reset_out_n);

    host_pin_model host_pin_model_inst (.sleep_req, .wake_req, .sleep_active_low,
        .wake_active_low, .sleep_pin, .wake_pin);

    always #5 clk_sys = ~clk_sys;

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp) begin
            failures++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic wait_cyc(input int n);
        repeat (n) @(negedge clk_sys);
    endtask : wait_cyc

    // Bounded wait; a miss shows up in the comparison that follows
    task automatic wait_hi(ref logic s, input logic v, input int n);
        for (int i = 0; i < n && s !== v; i++) @(negedge clk_sys);
    endtask : wait_hi

    task automatic pulse(ref logic s);
        @(negedge clk_sys);
        s = 1'h1;
        @(negedge clk_sys);
        s = 1'h0;
    endtask : pulse

    task automatic t_por;
        chk(reset_out_n, 1'h0);
        chk(supervisor_en, 1'h1);
        chk({pin_oe_n, pin_pullup_en}, 8'hFF);
        chk(analog_pwr_en, 6'h00);
        chk(reset_output_enable, 1'h1);
        wait_cyc(30);
        chk({hf_clock_out_en, low_freq_clock_out_en}, 2'h0);
        supervisor_ok = 1'h1;
        wait_cyc(TO + 2);
        chk(hf_clock_out_en, 1'h0);
        wait_hi(hf_clock_out_en, 1'h1, 12);
        chk({hf_clock_out_en, low_freq_clock_out_en}, 2'h3);
        wait_hi(reset_out_n, 1'h1, 10);
        chk(reset_out_n, 1'h1);
        fll_locked = 1'h1;
        wait_hi(irq_out, 1'h1, 10);
        chk({clock_locked_flag, irq_out}, 2'h3);
        fll_locked = 1'h0;
        wait_cyc(6);
        pulse(status_rd);
        wait_cyc(2);
        chk({clock_locked_flag, irq_out}, 2'h0);
    endtask : t_por

    task automatic t_supply;
        supply_detect_wdata = 1'h1;
        pulse(supply_monitor_ctrl_wr);
        chk(reset_output_enable, 1'h0);
        supply_low = 1'h1;
        wait_cyc(8);
        chk({low_digital_supply_flag, irq_out, reset_out_n}, 3'h5);
        reset_enable_wdata = 1'h1;
        pulse(supply_monitor_ctrl_wr);
        wait_cyc(2);
        chk({reset_output_enable, reset_out_n}, 2'h2);
        supply_low = 1'h0;
        wait_cyc(8);
        pulse(status_rd);
        wait_cyc(2);
        chk({low_digital_supply_flag, reset_out_n}, 2'h1);
    endtask : t_supply

    // Watchdog, crystal and slow-clock causes in turn
    task automatic t_causes;
        for (int i = 0; i < 3; i++) begin
            watchdog_expired = (i == 0);
            crystal_attached = (i == 1);
            clk32_ready = (i != 2);
            wait_cyc(1);
            watchdog_expired = 1'h0;
            wait_cyc(i == 0 ? 1 : 6);
            chk(reset_out_n, 1'h0);
            crystal_attached = 1'h0;
            clk32_ready = 1'h1;
            wait_hi(reset_out_n, 1'h1, 16);
            chk(reset_out_n, 1'h1);
        end
    endtask : t_causes

    task automatic t_sleep_sw;
        osc_keep_in_sleep = 1'h1;
        analog_sel = 6'h05;
        analog_wdata = 6'h3F;
        pulse(analog_wr);
        chk(analog_pwr_en, 6'h05);
        analog_sel = 6'h03;
        analog_wdata = 6'h02;
        pulse(analog_wr);
        chk(analog_pwr_en, 6'h06);
        pulse(sleep_reg_wr);
        chk({shutdown_flag, sleep_mode, hf_clock_out_en}, 3'h6);
        chk({analog_pwr_en, low_freq_clock_out_en, supervisor_en}, 8'h03);
        pulse(normal_reg_wr);
        chk({shutdown_flag, sleep_mode}, 2'h0);
        wait_cyc(2);
        chk({analog_pwr_en, hf_clock_out_en}, 7'h0D);
    endtask : t_sleep_sw

    task automatic t_sleep_cfg;
        osc_keep_in_sleep = 1'h0;
        pulse(sleep_cfg_wr);
        chk(shutdown_flag, 1'h0);
        sleep_request_bit = 1'h1;
        pulse(sleep_cfg_wr);
        chk({shutdown_flag, sleep_mode}, 2'h3);
        wait_cyc(2);
        chk(low_freq_clock_out_en, 1'h0);
        pulse(day_alarm);
        chk({shutdown_flag, sleep_mode, wake_event_flag}, 3'h1);
        pulse(status_rd);
        pulse(day_alarm);
        chk({sleep_mode, wake_event_flag, irq_out}, 3'h2);
    endtask : t_sleep_cfg

    // Both pin polarities; the pin must override writes and alarms
    task automatic t_pin_sleep;
        sleep_func_en = 1'h1;
        for (int p = 0; p < 2; p++) begin
            sleep_active_low = p[0];
            wait_cyc(12);
            sleep_req = 1'h1;
            wait_cyc(2);
            chk(sleep_mode, 1'h0);
            wait_hi(sleep_mode, 1'h1, 10);
            chk({sleep_mode, shutdown_flag}, 2'h2);
            pulse(normal_reg_wr);
            pulse(day_alarm);
            chk(sleep_mode, 1'h1);
            sleep_req = 1'h0;
            wait_hi(sleep_mode, 1'h0, 10);
            chk(sleep_mode, 1'h0);
        end
        sleep_func_en = 1'h0;
    endtask : t_pin_sleep

    task automatic t_wake_pin;
        wakeup_pin_function = 1'h1;
        for (int p = 0; p < 2; p++) begin
            wake_active_low = p[0];
            wait_cyc(12);
            pulse(sleep_reg_wr);
            pulse(status_rd);
            chk({sleep_mode, wake_event_flag}, 2'h2);
            wake_req = 1'h1;
            wait_hi(sleep_mode, 1'h0, 10);
            chk({sleep_mode, shutdown_flag, wake_event_flag}, 3'h1);
            wake_req = 1'h0;
            wait_cyc(6);
            pulse(status_rd);
            wake_req = 1'h1;
            wait_hi(wake_event_flag, 1'h1, 10);
            chk({sleep_mode, wake_event_flag}, 2'h1);
            wake_req = 1'h0;
            wait_cyc(6);
        end
    endtask : t_wake_pin

    // Pin setup, open interrupt mask, then supply trips with and without the detector
    task automatic t_cfg;
        pin_drive_wdata = 4'h5;
        pin_pull_wdata = 4'h9;
        pulse(pin_cfg_wr);
        chk({pin_oe_n, pin_pullup_en}, 8'hA9);
        pulse(irq_mask_wr);
        pulse(status_rd);
        chk(irq_out, 1'h0);
        pulse(day_alarm);
        chk({wake_event_flag, irq_out}, 2'h3);
        reset_enable_wdata = 1'h0;
        for (int d = 1; d >= 0; d--) begin
            supply_detect_wdata = d[0];
            pulse(supply_monitor_ctrl_wr);
            pulse(status_rd);
            supply_low = 1'h1;
            wait_cyc(6);
            chk(supervisor_en, d[0]);
            chk({low_digital_supply_flag, irq_out, reset_out_n}, {d[0], d[0], 1'h1});
            supply_low = 1'h0;
            wait_cyc(6);
        end
    endtask : t_cfg

    task automatic summarize;
        $display("checks %0d mismatches %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : summarize

    initial begin
        {supply_low, supervisor_ok, crystal_attached, fll_locked, sleep_func_en} = '0;
        {sleep_active_low, wakeup_pin_function, wake_active_low, osc_keep_in_sleep} = '0;
        {sleep_reg_wr, sleep_cfg_wr, sleep_request_bit, normal_reg_wr, day_alarm} = '0;
        {status_rd, watchdog_expired, supply_monitor_ctrl_wr, supply_detect_wdata} = '0;
        {reset_enable_wdata, irq_mask_wr, analog_wr, pin_cfg_wr, sleep_req, wake_req} = '0;
        {irq_mask_wdata, analog_sel, analog_wdata, pin_drive_wdata, pin_pull_wdata} = '0;
        clk32_ready = 1'h1;
        rst_n = 1'h0;
        repeat (8) @(negedge clk_sys);
        rst_n = 1'h1;
        t_por;
        t_supply;
        t_causes;
        t_sleep_sw;
        t_sleep_cfg;
        t_pin_sleep;
        t_wake_pin;
        t_cfg;
        summarize;
    end

    // The tests need about 350 cycles; some sixty times that means a hang
    initial begin
        #200000;
        failures++;
        summarize;
    end
endmodule : test_power_sleep_wake_reset_ctrl
